//--- spe_far_node.sv
// far serial node: slave when selected, or master through the send task
// assumes the bench resolves shared lines; slave side supports all four timings
`timescale 1ns/100ps
module spe_far_node (
   input wire logic i_cpol,
   input wire logic i_cpha,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_sel_n,
   input wire logic [7:0] i_tx,
   output wire logic o_sck,
   output logic o_mosi = 1'b0,
   output logic o_miso = 1'b0,
   output wire logic [7:0] o_rx
);
   // ************************************************************
   // shifter shared by both roles
   // ************************************************************
   logic [7:0] sh = 8'h00;
   logic master = 1'b0;
   logic sck_q = 1'b0;
   // clock stands at its idle level outside frames
   assign o_sck = master ? sck_q : i_cpol;
   assign o_rx = sh;
   // msb leaves first on select
   always @(negedge i_sel_n) if (!master) begin
      sh = i_tx;
      o_miso = sh[7];
   end
   // released line shows the inverse of its last bit
   always @(posedge i_sel_n) o_miso = ~o_miso;
   // sample on leading or trailing edge by phase; only follows the clock
   always @(i_sck) if (!master && !i_sel_n) begin
      if ((i_sck != i_cpol) ^ i_cpha) sh = {sh[6:0], i_mosi};
      else o_miso = sh[7];
   end
   // master byte at 200 ns clock period, leading-edge sampling only
   task automatic send(input logic [7:0] b);
      master = 1'b1;
      sck_q = i_cpol;
      sh = b;
      o_mosi = sh[7];
      for (int i = 0; i < 16; i++) begin
         #100 sck_q = ~sck_q;
         if (i % 2 == 0) sh = {sh[6:0], i_miso};
         else o_mosi = sh[7];
      end
      #100 o_mosi = ~o_mosi;
      master = 1'b0;
   endtask
endmodule

//--- spe_node.sv
// serial peripheral node: shifter, master clock divider and error flags
// assumes a cpu-side agent issuing one-cycle access strobes on i_sys_clk;
// pins arrive asynchronously and are synchronised here
//
// Notes on behaviour
// - data shifts msb first; out and in lines of all nodes joined.
// - only a master starts a transfer; a slave only follows the clock.
// - each master byte out is matched by a slave byte back, one clock.
// - with in and out joined per node, only simplex transfer works.
// - four clock polarity/phase timings; both ends must match.
// - a master sees a mode fault when its select input goes low.
// - mode fault sets its flag and interrupts when enabled.
// - mode fault clears port enable, releasing every output.
// - mode fault clears controller select, falling back to slave.
// - mode fault flag clears after status read with flag, then control write.
// - while mode fault is set, enable and controller bits cannot be set.
// - a slave never sets the mode fault flag; an old one may stay.
// - overrun when a byte completes while done flag is still set.
// - overrun sets its flag and interrupts when enabled.
// - after overrun the buffer keeps the first byte; later ones dropped.
// - overrun flag clears when software reads the status register.
// - data write during a transfer is dropped; the transfer continues.
// - dropped data write sets write collision, as master or slave.
// - write collision never interrupts.
// - received bytes sit in a buffer read in step with the cpu.
`timescale 1ns/100ps

module spe_node #(
   parameter int DATA_W = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   // cpu side access strobes
   input wire logic i_csr_rd,
   input wire logic i_cr_wr,
   input wire spe_pkg::spe_ctrl_s i_cr_wdata,
   input wire logic i_dr_wr,
   input wire logic [DATA_W-1:0] i_dr_wdata,
   input wire logic i_dr_rd,
   output spe_pkg::spe_ctrl_s o_ctrl,
   output spe_pkg::spe_stat_s o_status,
   output logic [DATA_W-1:0] o_rx_data,
   output logic o_busy,
   output logic o_irq,
   // serial pins
   input wire logic i_sck,
   output logic o_sck,
   output logic o_sck_oe,
   input wire logic i_mosi,
   output logic o_mosi,
   output logic o_mosi_oe,
   input wire logic i_miso,
   output logic o_miso,
   output logic o_miso_oe,
   input wire logic i_ss_n
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic mosi_s1_q, mosi_s2_q;
   logic miso_s1_q, miso_s2_q;
   logic ss_n_s1_q, ss_n_s2_q;

   // two flops per pin; the third sck flop only remembers the last level
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {sck_s1_q, sck_s2_q, sck_s3_q} <= 3'h0;
         {mosi_s1_q, mosi_s2_q, miso_s1_q, miso_s2_q} <= 4'h0;
         {ss_n_s1_q, ss_n_s2_q} <= 2'h3;
      end else begin
         {sck_s1_q, sck_s2_q, sck_s3_q} <= {i_sck, sck_s1_q, sck_s2_q};
         {mosi_s1_q, mosi_s2_q} <= {i_mosi, mosi_s1_q};
         {miso_s1_q, miso_s2_q} <= {i_miso, miso_s1_q};
         {ss_n_s1_q, ss_n_s2_q} <= {i_ss_n, ss_n_s1_q};
      end
   end

   // ************************************************************
   // state
   // ************************************************************
   spe_pkg::spe_ctrl_s ctrl_q, ctrl_d;
   spe_pkg::spe_stat_s stat_q, stat_d;
   logic [DATA_W-1:0] shreg_q, shreg_d, rxbuf_q, rxbuf_d;
   logic out_q, out_d;
   logic busy_q, busy_d;
   logic sck_q, sck_d;
   logic [5:0] div_q, div_d;
   logic [3:0] edge_cnt_q, edge_cnt_d;
   logic mode_fault_flag_arm_q, mode_fault_flag_arm_d;
   logic write_collision_flag_arm_q, write_collision_flag_arm_d;
   logic done_arm_q, done_arm_d;
   logic irq_q;

   // ************************************************************
   // decode
   // ************************************************************
   wire logic enabled = ctrl_q.port_enable;
   wire logic is_master = enabled & ctrl_q.controller_select;
   wire logic is_slave = enabled & ~ctrl_q.controller_select;
   wire logic ss_low = ~ss_n_s2_q;
   wire logic [5:0] half_per = 6'(spe_pkg::HALF_BASE << ctrl_q.rate);
   // master clock divider wraps once per half period
   wire logic m_edge = is_master & busy_q & (div_q == half_per - 6'h01);
   // slave follows synchronised clock edges while selected
   wire logic s_edge = is_slave & ss_low & (sck_s2_q != sck_s3_q);
   wire logic any_edge = m_edge | s_edge;
   // leading edge leaves the idle level
   wire logic cur_sck = is_master ? sck_q : sck_s3_q;
   wire logic lead_edge = (cur_sck == ctrl_q.clk_pol);
   wire logic sample_edge = any_edge & (lead_edge ^ ctrl_q.clk_pha);
   wire logic drive_edge = any_edge & ~(lead_edge ^ ctrl_q.clk_pha);
   wire logic din = is_master ? miso_s2_q : mosi_s2_q;
   wire logic [DATA_W-1:0] sh_shift = {shreg_q[DATA_W-2:0], din};
   wire logic last_edge = any_edge & (edge_cnt_q == spe_pkg::LAST_EDGE);
   wire logic [DATA_W-1:0] rx_byte = sample_edge ? sh_shift : shreg_q;
   // a master begins only from its own data write; a slave only from clock edges
   wire logic m_start = i_dr_wr & is_master & ~busy_q;
   wire logic collide = i_dr_wr & busy_q;
   // mode fault only while master; a slave never raises it
   wire logic mode_fault_flag_evt = is_master & ss_low;
   wire logic ovr_evt = last_edge & stat_q.transfer_done_flag;
   wire logic done_evt = last_edge & ~stat_q.transfer_done_flag;
   wire logic dr_access = i_dr_wr | i_dr_rd;

   // ************************************************************
   // shifter and transfer sequencing
   // ************************************************************
   always_comb begin
      shreg_d = shreg_q;
      out_d = out_q;
      busy_d = busy_q;
      sck_d = sck_q;
      div_d = div_q;
      edge_cnt_d = edge_cnt_q;
      if (!busy_q) begin
         sck_d = ctrl_q.clk_pol;
         div_d = 6'h00;
         edge_cnt_d = 4'h0;
      end
      // idle: a write preloads the next byte and its first bit
      if (i_dr_wr & ~busy_q) begin
         shreg_d = i_dr_wdata;
         out_d = i_dr_wdata[spe_pkg::BYTE_MSB];
      end
      busy_d = busy_q | m_start | (s_edge & ~busy_q);
      if (is_master & busy_q) begin
         div_d = m_edge ? 6'h00 : div_q + 6'h01;
         if (m_edge) begin
            sck_d = ~sck_q;
         end
      end
      if (any_edge) begin
         edge_cnt_d = edge_cnt_q + 4'h1;
      end
      if (sample_edge) begin
         shreg_d = sh_shift;
      end
      if (drive_edge) begin
         out_d = shreg_q[DATA_W-1];
      end
      if (last_edge) begin
         busy_d = 1'b0;
      end
      // deselect or disable aborts a partial byte; it never counts as done
      if (!enabled | (is_slave & ~ss_low) | mode_fault_flag_evt) begin
         busy_d = 1'b0;
         edge_cnt_d = 4'h0;
      end
   end

   // ************************************************************
   // control, flags and receive buffer
   // ************************************************************
   always_comb begin
      ctrl_d = ctrl_q;
      stat_d = stat_q;
      rxbuf_d = rxbuf_q;
      mode_fault_flag_arm_d = mode_fault_flag_arm_q;
      write_collision_flag_arm_d = write_collision_flag_arm_q;
      done_arm_d = done_arm_q;
      // status read arms the clearing sequences for the flags it saw set
      if (i_csr_rd) begin
         mode_fault_flag_arm_d = stat_q.mode_fault_flag;
         write_collision_flag_arm_d = stat_q.write_collision_flag;
         done_arm_d = stat_q.transfer_done_flag;
         stat_d.overrun_flag = 1'b0;
      end
      if (i_cr_wr) begin
         ctrl_d = i_cr_wdata;
         if (mode_fault_flag_arm_q) begin
            stat_d.mode_fault_flag = 1'b0;
            mode_fault_flag_arm_d = 1'b0;
         end else if (stat_q.mode_fault_flag) begin
            ctrl_d.port_enable = 1'b0;
            ctrl_d.controller_select = 1'b0;
         end
      end
      if (dr_access) begin
         if (write_collision_flag_arm_q) begin
            stat_d.write_collision_flag = 1'b0;
         end
         if (done_arm_q) begin
            stat_d.transfer_done_flag = 1'b0;
         end
         write_collision_flag_arm_d = 1'b0;
         done_arm_d = 1'b0;
      end
      // hardware events come last so a set beats a same-cycle clear
      if (collide) begin
         stat_d.write_collision_flag = 1'b1;
      end
      if (done_evt) begin
         rxbuf_d = rx_byte;
         stat_d.transfer_done_flag = 1'b1;
      end
      if (ovr_evt) begin
         stat_d.overrun_flag = 1'b1;
      end
      if (mode_fault_flag_evt) begin
         stat_d.mode_fault_flag = 1'b1;
         ctrl_d.port_enable = 1'b0;
         ctrl_d.controller_select = 1'b0;
      end
   end

   // write collision stays out of the interrupt term
   wire logic irq_d = ctrl_q.serial_irq_enable &
      (stat_q.transfer_done_flag | stat_q.overrun_flag | stat_q.mode_fault_flag);

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q <= spe_pkg::CTRL_RST;
         stat_q <= spe_pkg::STAT_RST;
         rxbuf_q <= DATA_W'(spe_pkg::DATA_RST);
         {mode_fault_flag_arm_q, write_collision_flag_arm_q, done_arm_q} <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         rxbuf_q <= rxbuf_d;
         {mode_fault_flag_arm_q, write_collision_flag_arm_q, done_arm_q} <= {mode_fault_flag_arm_d, write_collision_flag_arm_d, done_arm_d};
         irq_q <= irq_d;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shreg_q <= DATA_W'(spe_pkg::DATA_RST);
         {out_q, busy_q, sck_q} <= 3'h0;
         div_q <= 6'h00;
         edge_cnt_q <= 4'h0;
      end else begin
         shreg_q <= shreg_d;
         {out_q, busy_q, sck_q} <= {out_d, busy_d, sck_d};
         div_q <= div_d;
         edge_cnt_q <= edge_cnt_d;
      end
   end

   // ************************************************************
   // registered pin drivers
   // ************************************************************
   // enables follow the next control state so a fault releases pins at once;
   // with in and out joined, only one of the two enables is ever high
   logic sck_o_q, sck_oe_q, mosi_oe_q, miso_oe_q, dout_q;
   wire logic nxt_master = ctrl_d.port_enable & ctrl_d.controller_select;
   wire logic nxt_slave = ctrl_d.port_enable & ~ctrl_d.controller_select;

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {sck_o_q, sck_oe_q, mosi_oe_q, miso_oe_q, dout_q} <= 5'h0;
      end else begin
         sck_o_q <= sck_d;
         sck_oe_q <= nxt_master;
         mosi_oe_q <= nxt_master;
         miso_oe_q <= nxt_slave & ss_low;
         dout_q <= out_d;
      end
   end

   assign o_ctrl = ctrl_q;
   assign o_status = stat_q;
   assign o_rx_data = rxbuf_q;
   assign o_busy = busy_q;
   assign o_irq = irq_q;
   assign o_sck = sck_o_q;
   assign o_sck_oe = sck_oe_q;
   assign o_mosi = dout_q;
   assign o_mosi_oe = mosi_oe_q;
   assign o_miso = dout_q;
   assign o_miso_oe = miso_oe_q;

endmodule

//--- spe_node_sva.sv
// checker for the serial node: error flags, interrupt line and pin enables
// assumes only the node's ports; attached by the bind at the foot
`timescale 1ns/100ps
module spe_node_sva (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_csr_rd,
   input wire logic i_dr_wr,
   input wire spe_pkg::spe_ctrl_s o_ctrl,
   input wire spe_pkg::spe_stat_s o_status,
   input wire logic o_busy,
   input wire logic o_irq,
   input wire logic o_sck_oe,
   input wire logic o_mosi_oe,
   input wire logic o_miso_oe
);
   // ************************************************************
   // flag, interrupt and pin checks
   // ************************************************************
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // flags that may interrupt; write collision is left out on purpose
   wire logic req_w = o_status.transfer_done_flag | o_status.overrun_flag | o_status.mode_fault_flag;
   // both arms drop at the fault edge or one later
   sequence s_arms_down;
      ##[0:1] (!o_ctrl.port_enable && !o_ctrl.controller_select);
   endsequence
   sequence s_fault_rise;
      $rose(o_status.mode_fault_flag);
   endsequence
   a_irq_quiet: assert property (!req_w |=> !o_irq) else $error("irq without pending flag");
   a_irq_raise: assert property (o_ctrl.serial_irq_enable && req_w |=> o_irq) else $error("irq missing");
   a_fault_arms: assert property (s_fault_rise |-> s_arms_down) else $error("arms kept on fault");
   a_fault_master: assert property (s_fault_rise |-> $past(o_ctrl.controller_select)) else $error("slave fault");
   a_fault_hold: assert property (o_status.mode_fault_flag && $past(o_status.mode_fault_flag)
      |-> !o_ctrl.port_enable && !o_ctrl.controller_select) else $error("arm set under fault");
   // pin enables are registered from the next control state, so they line up with o_ctrl
   a_pins_off: assert property (!o_ctrl.port_enable |-> !o_sck_oe && !o_mosi_oe && !o_miso_oe)
      else $error("pin driven while disabled");
   a_slave_quiet: assert property (!o_ctrl.controller_select |-> !o_sck_oe && !o_mosi_oe)
      else $error("slave drives clock");
   a_write_collision_flag_set: assert property (i_dr_wr && o_busy |=> o_status.write_collision_flag) else $error("no write_collision_flag");
   a_ovr_clear: assert property (i_csr_rd && !o_busy |=> !o_status.overrun_flag) else $error("ovr kept");
   a_master_start: assert property (i_dr_wr && o_ctrl.port_enable && o_ctrl.controller_select && !o_busy
      && !o_status.mode_fault_flag |=> o_busy) else $error("master did not start");
endmodule

bind spe_node spe_node_sva spe_node_sva_inst (.i_sys_clk, .i_nrst, .i_csr_rd, .i_dr_wr, .o_ctrl, .o_status,
   .o_busy, .o_irq, .o_sck_oe, .o_mosi_oe, .o_miso_oe);

//--- spe_pkg.sv
// package for the serial peripheral node with error flags
// holds control/status layouts, reset values and timing counts shared by the design
package spe_pkg;

   // ************************************************************
   // control and status layouts
   // ************************************************************
   typedef struct packed {
      logic spare;             // no function, reads back as written
      logic serial_irq_enable;
      logic port_enable;
      logic controller_select; // 1: this node drives the shift clock
      logic clk_pol;           // idle level of the shift clock
      logic clk_pha;           // 0: sample on leading edge, 1: on trailing edge
      logic [1:0] rate;        // master half period = HALF_BASE << rate
   } spe_ctrl_s;

   typedef struct packed {
      logic transfer_done_flag;
      logic write_collision_flag;
      logic overrun_flag;
      logic mode_fault_flag;
   } spe_stat_s;

   // ************************************************************
   // reset values and counts
   // ************************************************************
   localparam spe_ctrl_s CTRL_RST = '{default: 1'b0};
   localparam spe_stat_s STAT_RST = '{default: 1'b0};
   localparam logic [7:0] DATA_RST = 8'h00;
   // least master half period in clock cycles; input sync costs two of them
   localparam logic [5:0] HALF_BASE = 6'h04;
   // two edges per bit, eight bits per byte
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam int BYTE_MSB = 7;

endpackage

//--- test_spe_node.sv
// self-checking bench for the serial node: master bytes, slave overrun, fault and collision
// assumes spe_pkg, spe_node, the checker and spe_far_node are compiled first
`timescale 1ns/100ps
module test_spe_node;
   // ************************************************************
   // signals and instances
   // ************************************************************
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_csr_rd = 1'b0;
   logic i_cr_wr = 1'b0;
   logic i_dr_wr = 1'b0;
   logic i_dr_rd = 1'b0;
   logic i_ss_n = 1'b1;
   logic sel_n = 1'b1;
   logic [7:0] i_dr_wdata = 8'h00;
   logic [7:0] far_tx = 8'h00;
   logic [7:0] far_rx, o_rx_data;
   spe_pkg::spe_ctrl_s i_cr_wdata = spe_pkg::CTRL_RST;
   spe_pkg::spe_ctrl_s cfg = spe_pkg::CTRL_RST;
   spe_pkg::spe_ctrl_s o_ctrl;
   spe_pkg::spe_stat_s o_status;
   logic o_busy, o_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, far_sck, far_mosi, far_miso;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;
   // each shared line follows whoever holds its enable
   wire logic i_sck = o_sck_oe ? o_sck : far_sck;
   wire logic i_mosi = o_mosi_oe ? o_mosi : far_mosi;
   wire logic i_miso = o_miso_oe ? o_miso : far_miso;
   spe_node spe_node_inst (.i_sys_clk, .i_nrst, .i_csr_rd, .i_cr_wr, .i_cr_wdata, .i_dr_wr, .i_dr_wdata, .i_dr_rd,
      .o_ctrl, .o_status, .o_rx_data, .o_busy, .o_irq, .i_sck, .o_sck, .o_sck_oe, .i_mosi, .o_mosi, .o_mosi_oe,
      .i_miso, .o_miso, .o_miso_oe, .i_ss_n);
   spe_far_node spe_far_node_inst (.i_cpol(cfg.clk_pol), .i_cpha(cfg.clk_pha), .i_sck, .i_mosi, .i_miso,
      .i_sel_n(sel_n), .i_tx(far_tx), .o_sck(far_sck), .o_mosi(far_mosi), .o_miso(far_miso), .o_rx(far_rx));
   // ************************************************************
   // clock, timeout and access tasks
   // ************************************************************
   always #12.5 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one-cycle strobe launched and dropped on falling edges
   task automatic pulse(ref logic s);
      @(negedge i_sys_clk) s = 1'b1;
      @(negedge i_sys_clk) s = 1'b0;
   endtask
   task automatic cr(input spe_pkg::spe_ctrl_s c);
      i_cr_wdata = c;
      pulse(i_cr_wr);
   endtask
   task automatic dw(input logic [7:0] d);
      i_dr_wdata = d;
      pulse(i_dr_wr);
   endtask
   task automatic wait_done();
      for (int k = 0; k < 3000 && o_status.transfer_done_flag !== 1'b1; k++) @(negedge i_sys_clk);
      repeat (2) @(negedge i_sys_clk);
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (10) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      chk("ctrl reset", 8'h00, o_ctrl);
      // master bytes in all four timings and rates, flags cleared between
      for (int m = 0; m < 4; m++) begin
         cfg = 8'h70 | 8'(m * 5);
         cr(cfg);
         far_tx = 8'h3c ^ 8'(m);
         sel_n = 1'b0;
         dw(8'ha5 - 8'(m));
         wait_done();
         chk("master rx", far_tx, o_rx_data);
         chk("far rx", 8'ha5 - 8'(m), far_rx);
         chk("done irq", 8'h01, o_irq);
         sel_n = 1'b1;
         pulse(i_csr_rd);
         pulse(i_dr_rd);
         chk("flags clear", 8'h00, o_status);
      end
      // second write lands mid-byte: dropped, byte goes out unchanged
      sel_n = 1'b0;
      dw(8'h81);
      dw(8'h42);
      // mid-byte only the collision flag is up, and it must not interrupt
      repeat (2) @(negedge i_sys_clk);
      chk("write_collision_flag only", 8'h04, o_status);
      chk("write_collision_flag no irq", 8'h00, o_irq);
      wait_done();
      chk("collision", 8'h0c, o_status);
      chk("far kept", 8'h81, far_rx);
      sel_n = 1'b1;
      pulse(i_csr_rd);
      pulse(i_dr_rd);
      chk("write_collision_flag clear", 8'h00, o_status);
      // select pulled low on a master
      cr(cfg);
      i_ss_n = 1'b0;
      repeat (6) @(negedge i_sys_clk);
      i_ss_n = 1'b1;
      chk("fault flag", 8'h01, o_status);
      chk("fault ctrl", 8'(cfg) & 8'hcf, o_ctrl);
      chk("fault irq", 8'h01, o_irq);
      cr(cfg);
      chk("refused", 8'(cfg) & 8'hcf, o_ctrl);
      pulse(i_csr_rd);
      cr(cfg);
      chk("fault cleared", 8'h00, o_status);
      chk("arms back", cfg, o_ctrl);
      // slave takes two bytes without clearing done
      cfg = 8'h20;
      cr(cfg);
      // the clock line drops to the new idle level as the pin driver lets go;
      // selecting before the synchroniser settles would count that as an edge
      repeat (4) @(negedge i_sys_clk);
      i_ss_n = 1'b0;
      dw(8'h77);
      spe_far_node_inst.send(8'h11);
      repeat (8) @(negedge i_sys_clk);
      chk("slave reply", 8'h77, far_rx);
      spe_far_node_inst.send(8'h22);
      repeat (8) @(negedge i_sys_clk);
      chk("overrun", 8'h0a, o_status);
      chk("first kept", 8'h11, o_rx_data);
      pulse(i_csr_rd);
      chk("ovr clear", 8'h08, o_status);
      i_ss_n = 1'b1;
      end_of_test();
   end
endmodule
